// ==== logic/psi5_init_params.svh ====
// timing figures, frame codes, counts and fifo depth for the initialization sequencer
`ifndef PSI5_INIT_PARAMS_SVH
`define PSI5_INIT_PARAMS_SVH
`define CLK_FREQ_MHZ        25
`define SETTLE_TIME_NS      10000
`define OC1_TIME_NS         20000
`define PME_TIME_NS         50000
`define OC2_TIME_NS         20000
`define PROG_ENTRY_PULSES   4
`define FIELDS_10BIT        32
`define FIELDS_8BIT         9
`define K_ASYNC             8
`define K_SYNC              4
`define FRAMES_PER_NIBBLE_10 2
`define FRAMES_PER_NIBBLE_8  4
`define ID_BASE_10          10'h20F
`define DATA_BASE_10        10'h21F
`define ID_BASE_8           10'h083
`define DATA_BASE_8         10'h087
`define BUSY_10             10'h1E8
`define READY_10            10'h1E7
`define UNLOCKED_10         10'h1E6
`define DEFECT_10           10'h1F4
`define BUSY_8              10'h07C
`define READY_8             10'h07B
`define UNLOCKED_8          10'h07A
`define DEFECT_8            10'h07D
`define FRAME_WIDTH         10
`define FIFO_DEPTH          8
`endif

// ==== logic/psi5_init_pkg.sv ====
// types shared by the initialization sequencer
package psi5_init_pkg;
  typedef enum logic [8:0] {
    ST_SETTLE = 9'h001,
    ST_OC1    = 9'h002,
    ST_PME    = 9'h004,
    ST_OC2    = 9'h008,
    ST_PROG   = 9'h010,
    ST_INIT2  = 9'h020,
    ST_BUSY   = 9'h040,
    ST_FINAL  = 9'h080,
    ST_NORMAL = 9'h100
  } init_state_e;
  typedef logic [9:0] frame_t;
endpackage

// ==== logic/psi5_init_sequencer.sv ====
// power-up initialization sequencer with its frame fifo
// Overview of operation
// [R1] three phases in order, phase one silent
// [R2] phase two: self-test runs while config frames go
// [R3] phase three: busy, then ready or defect
// [R4] afterwards stay in normal mode until reset
// [R5] settle, offset stage one, entry window, stage two
// [R6] sync series in window, unlocked: programming mode
// [R7] no entry sequence: continue into phase two
// [R8] internal steps include two-stage offset cancel
// [R9] data length picks 8-bit or 10-bit codes
// [R10] 10-bit: k ID/data pairs per field
// [R11] 8-bit: k high pairs then k low pairs
// [R12] nibble takes two or four frames
// [R13] 32 fields at 10-bit, 9 at 8-bit
// [R14] phase two length frames times k times fields
// [R15] k is 8 asynchronous, 4 synchronous
// [R16] config values then serial number data
// [R17] status codes busy, ready, unlocked, defect
// [R18] unlocked ready code when config lock clear
// [R19] ID codes from -497, or ending -128
// [R20] data codes from -481 for nibble value
// [R21] one frame per sync slot
`include "psi5_init_params.svh"
`timescale 1ns/1ps
`default_nettype none

module frame_fifo #(
  parameter int WIDTH = `FRAME_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready_o  = cnt_q != DEPTH[AW:0];
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem_q[rd_q];

  always_comb
  begin
    push = in_valid_i && in_ready_o;
    pop  = out_valid_o && out_ready_i;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push)
      mem_q[wr_q] <= in_data_i;
  end
endmodule

module psi5_init_sequencer
  import psi5_init_pkg::*;
#(
  parameter int SETTLE_CYCLES = (`SETTLE_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000,
  parameter int OC1_CYCLES    = (`OC1_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000,
  parameter int PME_CYCLES    = (`PME_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000,
  parameter int OC2_CYCLES    = (`OC2_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000,
  parameter int ENTRY_PULSES  = `PROG_ENTRY_PULSES,
  parameter int FIFO_DEPTH    = `FIFO_DEPTH
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       slot_tick_i,
  input  wire logic       sync_pulse_i,
  input  wire logic       data_10bit_i,
  input  wire logic       sync_mode_i,
  input  wire logic       lock_user_i,
  input  wire logic       config_lock_i,
  input  wire logic       self_test_done_i,
  input  wire logic       self_test_fail_i,
  input  wire logic [3:0] field_nibble_i,
  output logic [4:0]      field_sel_o,
  output logic [1:0]      phase_o,
  output logic            self_test_run_o,
  output logic            prog_mode_o,
  output logic            normal_mode_o,
  output logic            frame_valid_o,
  output logic [9:0]      frame_data_o,
  input  wire logic       frame_ready_i
);
  initial if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535 || OC1_CYCLES < 1
              || OC1_CYCLES > 65535 || PME_CYCLES < 1 || PME_CYCLES > 65535
              || OC2_CYCLES < 1 || OC2_CYCLES > 65535 || ENTRY_PULSES < 1
              || ENTRY_PULSES > 15)
    $error("timing or pulse count out of range");

  init_state_e state_q, state_d;
  logic [15:0] timer_q, timer_d;
  logic [3:0]  pulses_q, pulses_d;
  logic        entry_q, entry_d;
  logic        pend_q, pend_d;
  logic [4:0]  field_q, field_d;
  logic [2:0]  rep_q, rep_d;
  logic        low_q, low_d;
  logic        data_q, data_d;
  logic [1:0]  phase_d;
  logic        run_d, prog_d, normal_d;
  logic        push, fifo_ready, fifo_valid;
  frame_t      word, fifo_word;
  logic [2:0]  k_last;
  logic [4:0]  f_last;

  function automatic frame_t id_code(input logic ten, input logic [3:0] idx);
    id_code = ten ? `ID_BASE_10 - {6'h00, idx} : `ID_BASE_8 - {8'h00, idx[1:0]}; // R19
  endfunction

  function automatic frame_t data_code(input logic ten, input logic [3:0] nib);
    data_code = ten ? `DATA_BASE_10 - {6'h00, nib} : `DATA_BASE_8 - {8'h00, nib[1:0]}; // R20
  endfunction

  function automatic logic [15:0] cyc(input int n);
    cyc = 16'(n - 1);
  endfunction

  // frame word for the current slot
  always_comb
  begin
    word = '0;
    if (state_q == ST_INIT2)
    begin
      if (!data_q)
        word = id_code(data_10bit_i, data_10bit_i ? field_q[3:0] : {2'b00, field_q[0], low_q});
      else
        word = data_code(data_10bit_i,
                         data_10bit_i ? field_nibble_i // R16
                                      : {2'b00, low_q ? field_nibble_i[1:0] : field_nibble_i[3:2]});
    end
    else if (state_q == ST_BUSY)
      word = data_10bit_i ? `BUSY_10 : `BUSY_8; // R17
    else if (state_q == ST_FINAL)
    begin
      if (self_test_fail_i)
        word = data_10bit_i ? `DEFECT_10 : `DEFECT_8; // R3
      else if (!config_lock_i)
        word = data_10bit_i ? `UNLOCKED_10 : `UNLOCKED_8; // R18
      else
        word = data_10bit_i ? `READY_10 : `READY_8; // R17
    end
  end

  always_comb
  begin
    state_d  = state_q;
    timer_d  = timer_q == '0 ? '0 : timer_q - 16'h0001;
    pulses_d = pulses_q;
    entry_d  = entry_q;
    field_d  = field_q;
    rep_d    = rep_q;
    low_d    = low_q;
    data_d   = data_q;
    k_last   = sync_mode_i ? 3'(`K_SYNC - 1) : 3'(`K_ASYNC - 1); // R15
    f_last   = data_10bit_i ? 5'(`FIELDS_10BIT - 1) : 5'(`FIELDS_8BIT - 1); // R13
    // a tick is held pending until pushed; one landing while a frame already waits merges into it
    pend_d   = slot_tick_i || pend_q;
    push     = 1'b0;
    case (state_q)
      ST_SETTLE:
        if (timer_q == '0)
        begin
          state_d = ST_OC1; // R5 R8
          timer_d = cyc(OC1_CYCLES);
        end
      ST_OC1:
        if (timer_q == '0)
        begin
          state_d  = ST_PME; // R5
          timer_d  = cyc(PME_CYCLES);
          pulses_d = '0;
        end
      ST_PME:
      begin
        if (sync_pulse_i && pulses_q != 4'hF)
          pulses_d = pulses_q + 4'h1;
        if (timer_q == '0)
        begin
          state_d = ST_OC2; // R5 R8
          timer_d = cyc(OC2_CYCLES);
          entry_d = (pulses_d >= 4'(ENTRY_PULSES)) && !lock_user_i; // R6
        end
      end
      ST_OC2:
        if (timer_q == '0)
        begin
          state_d = entry_q ? ST_PROG : ST_INIT2; // R6 R7
          pend_d  = 1'b0;
          field_d = '0;
          rep_d   = '0;
          low_d   = 1'b0;
          data_d  = 1'b0;
        end
      ST_INIT2:
        if (pend_q && fifo_ready)
        begin
          push   = 1'b1; // R21
          pend_d = slot_tick_i;
          data_d = !data_q; // R12
          if (data_q)
          begin
            rep_d = rep_q + 3'h1;
            if (rep_q == k_last)
            begin
              rep_d = '0; // R10 R11
              if (!data_10bit_i && !low_q)
                low_d = 1'b1; // R11
              else
              begin
                low_d   = 1'b0;
                field_d = field_q + 5'h01;
                if (field_q == f_last)
                  state_d = ST_BUSY; // R1 R14
              end
            end
          end
        end
      ST_BUSY:
        if (pend_q && fifo_ready)
        begin
          push   = 1'b1; // R3
          pend_d = slot_tick_i;
          if (self_test_done_i)
            state_d = ST_FINAL;
        end
      ST_FINAL:
        if (pend_q && fifo_ready)
        begin
          push    = 1'b1; // R3
          pend_d  = 1'b0;
          state_d = ST_NORMAL; // R4
        end
      ST_PROG, ST_NORMAL:
        pend_d = 1'b0; // R4
      default:
      begin
        state_d = ST_SETTLE;
        timer_d = cyc(SETTLE_CYCLES);
      end
    endcase
    if (state_q inside {ST_SETTLE, ST_OC1, ST_PME, ST_OC2})
      pend_d = 1'b0; // R1
    phase_d  = state_d inside {ST_INIT2} ? 2'd2 :
               state_d inside {ST_BUSY, ST_FINAL} ? 2'd3 :
               state_d inside {ST_PROG, ST_NORMAL} ? 2'd0 : 2'd1;
    run_d    = state_d == ST_INIT2; // R2
    prog_d   = state_d == ST_PROG;
    normal_d = state_d == ST_NORMAL;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_q         <= ST_SETTLE;
      timer_q         <= cyc(SETTLE_CYCLES);
      pulses_q        <= '0;
      entry_q         <= 1'b0;
      pend_q          <= 1'b0;
      field_q         <= '0;
      rep_q           <= '0;
      low_q           <= 1'b0;
      data_q          <= 1'b0;
      phase_o         <= 2'd1;
      self_test_run_o <= 1'b0;
      prog_mode_o     <= 1'b0;
      normal_mode_o   <= 1'b0;
      field_sel_o     <= '0;
    end
    else
    begin
      state_q         <= state_d;
      timer_q         <= timer_d;
      pulses_q        <= pulses_d;
      entry_q         <= entry_d;
      pend_q          <= pend_d;
      field_q         <= field_d;
      rep_q           <= rep_d;
      low_q           <= low_d;
      data_q          <= data_d;
      phase_o         <= phase_d;
      self_test_run_o <= run_d;
      prog_mode_o     <= prog_d;
      normal_mode_o   <= normal_d;
      field_sel_o     <= field_d;
    end
  end

  frame_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (word),
    .out_valid_o (fifo_valid),
    .out_ready_i (!frame_valid_o || frame_ready_i),
    .out_data_o  (fifo_word)
  );

  // output stage keeps the frame port straight off flip-flops
  logic   fv_d;
  frame_t fd_d;
  always_comb
  begin
    fv_d = frame_valid_o && !frame_ready_i;
    fd_d = frame_data_o;
    if (!frame_valid_o || frame_ready_i)
    begin
      fv_d = fifo_valid;
      fd_d = fifo_valid ? fifo_word : frame_data_o;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      frame_valid_o <= 1'b0;
      frame_data_o  <= '0;
    end
    else
    begin
      frame_valid_o <= fv_d;
      frame_data_o  <= fd_d;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  silent_phase_one_a: assert property (state_q inside {ST_SETTLE, ST_OC1, ST_PME, ST_OC2}
    |-> !push) else $error("frame pushed in phase one"); // R1
  stage_order_a: assert property (state_q == ST_OC1 && state_d != ST_OC1
    |=> state_q == ST_PME) else $error("entry window did not follow stage one"); // R5
  window_len_a: assert property ($rose(state_q == ST_PME) |-> (state_q == ST_PME)[*8])
    else $error("entry window too short"); // R5
  prog_entry_a: assert property (state_q == ST_OC2 && timer_q == '0 && entry_q
    |=> prog_mode_o && state_q == ST_PROG) else $error("programming entry missed"); // R6
  no_entry_a: assert property (state_q == ST_OC2 && timer_q == '0 && !entry_q
    |=> phase_o == 2'd2 && self_test_run_o) else $error("phase two not entered"); // R7 R2
  id_then_data_a: assert property (push && state_q == ST_INIT2 && !data_q
    |=> data_q) else $error("data frame did not follow id"); // R12
  field_step_a: assert property (push && state_q == ST_INIT2 && data_q && rep_q != k_last
    |=> field_q == $past(field_q)) else $error("field advanced before k pairs"); // R10 R11
  code_range_a: assert property (push && state_q == ST_INIT2 && data_10bit_i
    |-> (word >= 10'h200 && word <= 10'h21F)) else $error("init code out of range"); // R19 R20
  busy_first_a: assert property ($rose(state_q == ST_FINAL) |-> $past(state_q) == ST_BUSY)
    else $error("final status without busy"); // R3
  normal_stays_a: assert property (normal_mode_o |=> normal_mode_o && !push)
    else $error("left normal mode"); // R4
  slot_push_a: assert property (push |-> pend_q) else $error("frame without slot"); // R21

  prog_seen_c: cover property (prog_mode_o);
  ten_bit_done_c: cover property (data_10bit_i && normal_mode_o);
  eight_bit_done_c: cover property (!data_10bit_i && normal_mode_o);
  defect_sent_c: cover property (push && state_q == ST_FINAL && self_test_fail_i);
endmodule

`default_nettype wire

// ==== testbench/psi5_receiver_model.sv ====
// receiver stand-in: slot ticks at a fixed period, stream ready that can stall
`timescale 1ns/1ps
`default_nettype none
module psi5_receiver_model #(
  parameter int PERIOD = 6
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       stall_i,
  input  wire logic [7:0] rnd_i,
  output logic            slot_tick_o,
  output logic            frame_ready_o
);
  int cnt = 0;
  initial
  begin
    slot_tick_o = 1'h0;
    frame_ready_o = 1'h0;
  end
  // ticks keep coming in every phase; the device must ignore them outside phases two and three
  always @(negedge ref_clk_i)
  begin
    cnt = (rst_i || cnt == PERIOD - 1) ? 0 : cnt + 1;
    slot_tick_o <= (cnt == 0) && !rst_i;
    frame_ready_o <= !stall_i && rnd_i[0];
  end
endmodule
`default_nettype wire

// ==== testbench/psi5_init_sequencer_bench.sv ====
// self-checking bench for the initialization sequencer
`include "psi5_init_params.svh"
`timescale 1ns/1ps
`default_nettype none
module psi5_init_sequencer_bench;
  import psi5_init_pkg::*;
  logic       ref_clk_i = 1'h0;
  logic       rst_i = 1'h1;
  logic       sync_pulse_i = 1'h0;
  logic       data_10bit_i = 1'h1;
  logic       sync_mode_i = 1'h0;
  logic       lock_user_i = 1'h1;
  logic       config_lock_i = 1'h1;
  logic       self_test_fail_i = 1'h0;
  logic       stall = 1'h0;
  logic [7:0] rnd = 8'h4C;
  logic [7:0] nseed = 8'h4C;
  logic [3:0] nib_tab [32];
  logic       slot_tick, frame_ready, st_run, prog_mode, normal_mode, frame_valid;
  logic [4:0] field_sel;
  logic [1:0] phase;
  frame_t     frame_data;
  frame_t     got [$];
  int         busy_cnt, p1_cnt, fail_count, num_checks;
  wire logic       self_test_done_i = (busy_cnt >= 3);
  wire logic [3:0] field_nibble_i = nib_tab[field_sel];

  always #20 ref_clk_i = ~ref_clk_i;

  psi5_init_sequencer #(.SETTLE_CYCLES(8), .OC1_CYCLES(8), .PME_CYCLES(40), .OC2_CYCLES(8))
    psi5_init_sequencer_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .slot_tick_i(slot_tick),
    .sync_pulse_i(sync_pulse_i), .data_10bit_i(data_10bit_i), .sync_mode_i(sync_mode_i),
    .lock_user_i(lock_user_i), .config_lock_i(config_lock_i),
    .self_test_done_i(self_test_done_i), .self_test_fail_i(self_test_fail_i),
    .field_nibble_i(field_nibble_i), .field_sel_o(field_sel), .phase_o(phase),
    .self_test_run_o(st_run), .prog_mode_o(prog_mode), .normal_mode_o(normal_mode),
    .frame_valid_o(frame_valid), .frame_data_o(frame_data), .frame_ready_i(frame_ready));

  psi5_receiver_model psi5_receiver_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .stall_i(stall), .rnd_i(rnd), .slot_tick_o(slot_tick), .frame_ready_o(frame_ready));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // expected i-th phase-two frame for repetition count k
  function automatic frame_t exp_frame(input logic d10, input int k, input int i);
    int         per, f, r;
    logic       lo;
    logic [3:0] nb;
    per = d10 ? 2 * k : 4 * k;
    f = i / per;
    r = i % per;
    nb = nib_tab[f];
    lo = (r >= 2 * k);
    if (d10)
      return (r % 2) ? frame_t'(`DATA_BASE_10 - nb) : frame_t'(`ID_BASE_10 - f[3:0]);
    if (r % 2)
      return frame_t'(`DATA_BASE_8 - (lo ? nb[1:0] : nb[3:2]));
    return frame_t'(`ID_BASE_8 - {f[0], lo});
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge ref_clk_i)
  begin
    rnd <= lfsr(rnd);
    if (!rst_i)
    begin
      if (phase == 2'h1)
      begin
        p1_cnt++;
        chk(frame_valid, 1'h0);
      end
      if (phase == 2'h2)
        chk(st_run, 1'h1);
      if (phase == 2'h3)
        chk(st_run, 1'h0);
      if (frame_valid && frame_ready)
      begin
        got.push_back(frame_data);
        // non-blocking: this count feeds self_test_done_i, which the design samples on this edge
        if (frame_data == `BUSY_10 || frame_data == `BUSY_8)
          busy_cnt <= busy_cnt + 1;
      end
    end
  end

  task automatic run_case(input logic d10, sm, cl, fl, lu);
    int     k, n, i, sz;
    frame_t fin;
    @(negedge ref_clk_i);
    rst_i = 1'h1;
    data_10bit_i = d10;
    sync_mode_i = sm;
    config_lock_i = cl;
    self_test_fail_i = fl;
    lock_user_i = lu;
    for (i = 0; i < 32; i++)
    begin
      nseed = lfsr(nseed);
      nib_tab[i] = nseed[3:0];
    end
    repeat (20) @(negedge ref_clk_i);
    got.delete();
    busy_cnt = 0;
    p1_cnt = 0;
    rst_i = 1'h0;
    // four sync pulses land inside the entry window
    for (i = 0; i < 4; i++)
    begin
      repeat (i == 0 ? 20 : 3) @(negedge ref_clk_i);
      sync_pulse_i = 1'h1;
      @(negedge ref_clk_i);
      sync_pulse_i = 1'h0;
    end
    n = 0;
    while (!normal_mode && !prog_mode && n < 20000)
    begin
      @(negedge ref_clk_i);
      n++;
      stall = (n > 300 && n < 400); // fifo fills to its limit while stalled
    end
    // normal mode is flagged as the final code is pushed; let the fifo drain to the receiver
    repeat (100) @(negedge ref_clk_i);
    chk(p1_cnt >= 64 && p1_cnt <= 68, 1'h1);
    chk(phase, 2'h0);
    chk(prog_mode, !lu);
    chk(normal_mode, lu);
    if (!lu)
    begin
      chk(got.size(), 16'h0);
      return;
    end
    k = sm ? `K_SYNC : `K_ASYNC;
    n = (d10 ? `FRAMES_PER_NIBBLE_10 * `FIELDS_10BIT : `FRAMES_PER_NIBBLE_8 * `FIELDS_8BIT) * k;
    chk(got.size() >= n + 2, 1'h1);
    for (i = 0; i < n; i++)
      chk(got[i], exp_frame(d10, k, i));
    for (i = n; i < got.size() - 1; i++)
      chk(got[i], d10 ? `BUSY_10 : `BUSY_8);
    fin = fl ? (d10 ? `DEFECT_10 : `DEFECT_8) :
          cl ? (d10 ? `READY_10 : `READY_8) : (d10 ? `UNLOCKED_10 : `UNLOCKED_8);
    chk(got[got.size() - 1], fin);
    sz = got.size();
    repeat (40) @(negedge ref_clk_i);
    chk(got.size(), sz);
    chk(normal_mode, 1'h1);
  endtask

  initial
  begin
    busy_cnt = 0;
    p1_cnt = 0;
    fail_count = 0;
    num_checks = 0;
    run_case(1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
    run_case(1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
    run_case(1'h1, 1'h1, 1'h0, 1'h1, 1'h1);
    run_case(1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
    run_case(1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    finish_test();
  end

  // a hang past the expected span counts as a mismatch
  initial
  begin
    #(40 * 100000);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
